// [design/mpc_defs.svh]
// timing counts, ratios and reset values for the memory phy clock block
// Notes on behaviour
// - one pll makes fabric, refs, sync pulse
// - 400..1066 MHz: both refs equal memory clock
// - below 400: second ref 2x or 4x
// - both refs come from same pll
// - multiply/divide default to input equals memory
// - recommend vco at least 1 GHz, M<=10
// - fabric at quarter rate, pll outputs memory clock
// - write phase gen: two in-phase byte clocks plus a shifted one
// - shifted clock runs 90 degrees late; strobe stays in phase with byte clock
// - write gen drives strobe, tristates, out fifo read
// - read byte clock aligned to incoming strobe
// - read div clock aligned, feeds deserializer, in fifo
// - read gen drives in fifo write enable
// - calibration reset includes pll lock
`ifndef MPC_DEFS_SVH
`define MPC_DEFS_SVH
`define MPC_CLK_MHZ 250
`define MPC_REF_LOW_MHZ 400
`define MPC_REF_HIGH_MHZ 1066
`define MPC_VCO_MIN_MHZ 1000
`define MPC_MULT_MAX 10
`define MPC_FABRIC_RATIO 4
`define MPC_SYNC_PERIOD 16
`define MPC_CAL_RST_NS 60
`define MPC_CAL_RST_CYC ((`MPC_CAL_RST_NS * `MPC_CLK_MHZ + 999) / 1000)
`define MPC_LOCK_STAGES 3
`endif

// [design/mpc_pkg.sv]
// types shared by the memory phy clock block
package mpc_pkg;
  // write side per-group outputs
  typedef struct packed {
    logic byte_clk;
    logic byte_clk_div;
    logic byte_clk_shifted;
    logic strobe_gen;
    logic strobe_oe_n;
    logic data_oe_n;
    logic out_queue_read_enable;
  } mpc_wr_grp_t;
  // read side per-group outputs
  typedef struct packed {
    logic byte_clk;
    logic byte_clk_div;
    logic input_queue_write_enable;
  } mpc_rd_grp_t;
  // reference selection for the second phase reference
  typedef enum logic [2:0] {
    MPC_REF_X1 = 3'h1,
    MPC_REF_X2 = 3'h2,
    MPC_REF_X4 = 3'h4
  } mpc_ref_mult_t;
endpackage : mpc_pkg

// [design/mpc_write_phase_gen.sv]
// write-side phase generator for one byte group, modelled at ref rate
`timescale 1ns/1ps
`default_nettype none
module mpc_write_phase_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic write_active,
  output mpc_pkg::mpc_wr_grp_t grp
);
  // quarter phase counter, one step per reference quarter
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  mpc_pkg::mpc_wr_grp_t grp_reg;
  mpc_pkg::mpc_wr_grp_t grp_next;

  // next phase and derived clocks, all stepped by one phase counter, shifted clock a quarter late
  always_comb
  begin
    phase_next = phase_reg + 2'h1;
    div_next = div_reg;
    if (phase_reg == 2'h3)
    begin
      div_next = div_reg + 2'h1;
    end
    grp_next = grp_reg;
    grp_next.byte_clk = ~phase_reg[1];
    grp_next.byte_clk_div = ~div_reg[1];
    // shifted by one quarter period, ninety degrees late
    grp_next.byte_clk_shifted = phase_reg[1] ^ phase_reg[0];
    grp_next.strobe_gen = write_active & ~phase_reg[1];
    grp_next.strobe_oe_n = ~write_active;
    grp_next.data_oe_n = ~write_active;
    grp_next.out_queue_read_enable = write_active & (phase_reg == 2'h0);
  end

  // register stage; reset keeps pins released
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_reg <= 2'h0;
      div_reg <= 2'h0;
      grp_reg <= '{default: 1'b0, strobe_oe_n: 1'b1, data_oe_n: 1'b1};
    end
    else
    begin
      phase_reg <= phase_next;
      div_reg <= div_next;
      grp_reg <= grp_next;
    end
  end

  assign grp = grp_reg;
endmodule : mpc_write_phase_gen
`default_nettype wire

// [design/mpc_read_phase_gen.sv]
// read-side phase generator for one byte group, aligns to strobe
`timescale 1ns/1ps
`default_nettype none
module mpc_read_phase_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic dqs_in,
  output mpc_pkg::mpc_rd_grp_t grp
);
  // three stage sampler on the pin strobe
  logic [2:0] dqs_sync_reg;
  logic [2:0] dqs_sync_next;
  logic dqs_state_reg;
  logic dqs_state_next;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  mpc_pkg::mpc_rd_grp_t grp_reg;
  mpc_pkg::mpc_rd_grp_t grp_next;

  // accepted level updates only when stages two and three agree
  always_comb
  begin
    dqs_sync_next = {dqs_sync_reg[1:0], dqs_in};
    dqs_state_next = dqs_state_reg;
    if (dqs_sync_reg[1] == dqs_sync_reg[2])
    begin
      dqs_state_next = dqs_sync_reg[2];
    end
    div_next = div_reg;
    // divided clock steps on each accepted rising strobe edge
    if (dqs_state_next & ~dqs_state_reg)
    begin
      div_next = div_reg + 2'h1;
    end
    grp_next.byte_clk = dqs_state_reg;
    grp_next.byte_clk_div = div_reg[1];
    // one write per divided period, on its rising edge
    grp_next.input_queue_write_enable =
      dqs_state_next & ~dqs_state_reg & (div_reg == 2'h1);
  end

  // register stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dqs_sync_reg <= 3'h0;
      dqs_state_reg <= 1'b0;
      div_reg <= 2'h0;
      grp_reg <= '0;
    end
    else
    begin
      dqs_sync_reg <= dqs_sync_next;
      dqs_state_reg <= dqs_state_next;
      div_reg <= div_next;
      grp_reg <= grp_next;
    end
  end

  assign grp = grp_reg;
endmodule : mpc_read_phase_gen
`default_nettype wire

// [design/mpc_clock_gen.sv]
// top of memory phy clock generation: reset, pll model, phase gens
`timescale 1ns/1ps
`default_nettype none
`include "mpc_defs.svh"
module mpc_clock_gen #(
  parameter int BYTE_GROUPS = 2,
  parameter int MEM_CLK_MHZ = 800,
  parameter int IN_CLK_MHZ = 800,
  parameter int PLL_MULT = 2,
  parameter int PLL_DIV = 2,
  parameter bit CAL_REF_FROM_PLL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pll_lock,
  input wire logic write_active,
  input wire logic [BYTE_GROUPS-1:0] dqs_in,
  output logic fabric_rst,
  output logic fabric_clk_en,
  output logic mem_clk,
  output logic sync_pulse,
  output mpc_pkg::mpc_ref_mult_t ref2_mult,
  output logic ref_ok,
  output logic vco_ok,
  output logic cal_rst,
  output mpc_pkg::mpc_wr_grp_t [BYTE_GROUPS-1:0] wr_grp,
  output mpc_pkg::mpc_rd_grp_t [BYTE_GROUPS-1:0] rd_grp
);
  // static frequency plan, evaluated at elaboration
  localparam int VCO_MHZ = IN_CLK_MHZ * PLL_MULT;
  localparam int REF2_MHZ =
    (MEM_CLK_MHZ >= `MPC_REF_LOW_MHZ) ? MEM_CLK_MHZ :
    (2 * MEM_CLK_MHZ >= `MPC_REF_LOW_MHZ) ? 2 * MEM_CLK_MHZ :
    4 * MEM_CLK_MHZ;
  localparam mpc_pkg::mpc_ref_mult_t REF2_SEL =
    (REF2_MHZ == MEM_CLK_MHZ) ? mpc_pkg::MPC_REF_X1 :
    (REF2_MHZ == 2 * MEM_CLK_MHZ) ? mpc_pkg::MPC_REF_X2 :
    mpc_pkg::MPC_REF_X4;
  localparam bit REF_IN_RANGE = (REF2_MHZ >= `MPC_REF_LOW_MHZ) &&
    (REF2_MHZ <= `MPC_REF_HIGH_MHZ);
  // output divide must bring the oscillator back to the memory clock
  localparam bit PLAN_MATCH = (VCO_MHZ == MEM_CLK_MHZ * PLL_DIV);
  // advisory only: out-of-range plan flagged, not blocked
  localparam bit VCO_IN_RANGE = (VCO_MHZ >= `MPC_VCO_MIN_MHZ) &&
    (PLL_MULT <= `MPC_MULT_MAX);
  localparam int CAL_CYC = `MPC_CAL_RST_CYC;

  // lock sampler, three stages, accepted when two and three agree
  logic [2:0] lock_sync_reg;
  logic [2:0] lock_sync_next;
  logic locked_reg;
  logic locked_next;
  logic fab_rst_reg;
  logic fab_rst_next;
  // quarter rate enable counter and sync pulse counter
  logic [1:0] quarter_reg;
  logic [1:0] quarter_next;
  logic [3:0] sync_cnt_reg;
  logic [3:0] sync_cnt_next;
  logic sync_reg;
  logic sync_next;
  logic mem_clk_reg;
  logic mem_clk_next;
  // calibration reset stretch counter
  logic [7:0] cal_cnt_reg;
  logic [7:0] cal_cnt_next;
  logic cal_rst_reg;
  logic cal_rst_next;

  // lock sampling and synchronous reset release
  always_comb
  begin
    lock_sync_next = {lock_sync_reg[1:0], pll_lock};
    locked_next = locked_reg;
    if (lock_sync_reg[1] == lock_sync_reg[2])
    begin
      locked_next = lock_sync_reg[2];
    end
    // loss of accepted lock re-enters reset on the next cycle
    fab_rst_next = ~locked_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_sync_reg <= 3'h0;
      locked_reg <= 1'b0;
      fab_rst_reg <= 1'b1;
    end
    else
    begin
      lock_sync_reg <= lock_sync_next;
      locked_reg <= locked_next;
      fab_rst_reg <= fab_rst_next;
    end
  end

  // shared divider: quarter enable, memory clock, sync pulse all one source
  always_comb
  begin
    quarter_next = quarter_reg + 2'h1;
    mem_clk_next = ~mem_clk_reg;
    sync_cnt_next = sync_cnt_reg + 4'h1;
    // one pulse per period keeps all bank controls aligned
    sync_next = (sync_cnt_reg == 4'(`MPC_SYNC_PERIOD - 1));
  end

  always_ff @(posedge clk)
  begin
    if (fab_rst_reg)
    begin
      quarter_reg <= 2'h0;
      mem_clk_reg <= 1'b0;
      sync_cnt_reg <= 4'h0;
      sync_reg <= 1'b0;
    end
    else
    begin
      quarter_reg <= quarter_next;
      mem_clk_reg <= mem_clk_next;
      sync_cnt_reg <= sync_cnt_next;
      sync_reg <= sync_next;
    end
  end

  // calibration reset, held while lock is absent when pll feeds it
  always_comb
  begin
    cal_cnt_next = cal_cnt_reg;
    cal_rst_next = cal_rst_reg;
    if (CAL_REF_FROM_PLL && !locked_reg)
    begin
      cal_cnt_next = 8'h00;
      cal_rst_next = 1'b1;
    end
    else if (cal_cnt_reg < 8'(CAL_CYC))
    begin
      // stretch keeps reset past minimum width
      cal_cnt_next = cal_cnt_reg + 8'h01;
      cal_rst_next = 1'b1;
    end
    else
    begin
      cal_rst_next = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_cnt_reg <= 8'h00;
      cal_rst_reg <= 1'b1;
    end
    else
    begin
      cal_cnt_reg <= cal_cnt_next;
      cal_rst_reg <= cal_rst_next;
    end
  end

  // per group phase generators, all on one reset so refs stay in phase
  genvar g;
  generate
    for (g = 0; g < BYTE_GROUPS; g++)
    begin : g_grp
      mpc_write_phase_gen u_wr (
        .clk(clk),
        .rst(fab_rst_reg),
        .write_active(write_active),
        .grp(wr_grp[g])
      );
      mpc_read_phase_gen u_rd (
        .clk(clk),
        .rst(fab_rst_reg),
        .dqs_in(dqs_in[g]),
        .grp(rd_grp[g])
      );
    end
  endgenerate

  // outputs: the calibration clock itself comes from outside
  assign fabric_rst = fab_rst_reg;
  assign fabric_clk_en = (quarter_reg == 2'h3) & ~fab_rst_reg;
  assign mem_clk = mem_clk_reg;
  assign sync_pulse = sync_reg;
  assign ref2_mult = REF2_SEL;
  assign ref_ok = REF_IN_RANGE & PLAN_MATCH;
  assign vco_ok = VCO_IN_RANGE;
  assign cal_rst = cal_rst_reg;
endmodule : mpc_clock_gen
`default_nettype wire

// [tb/mpc_mem_model.sv]
// read strobe model of the memory devices on the far side
`timescale 1ns/1ps
`default_nettype none
module mpc_mem_model #(
  parameter int BG = 2
) (
  input wire logic clk,
  input wire logic burst,
  input wire logic [3:0] half,
  output logic [BG-1:0] dqs
);
  int edges = 0; // strobe edges left in this burst
  int cnt = 0; // cycles left in this half period
  logic lvl = 1'b0; // terminated strobe rests low between bursts
  // eight rising strobe edges per burst, half period set by the bench
  always @(posedge clk)
  begin
    if (burst)
    begin
      edges <= 16;
      cnt <= 0;
    end
    else if (edges > 0 && cnt == 0)
    begin
      lvl <= ~lvl;
      edges <= edges - 1;
      cnt <= half - 1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign dqs = {BG{lvl}};
endmodule : mpc_mem_model
`default_nettype wire

// [tb/mpc_clock_gen_properties.sv]
// port checker for the memory phy clock block
`timescale 1ns/1ps
`default_nettype none
module mpc_clock_gen_properties #(
  parameter int BYTE_GROUPS = 2,
  parameter int MEM_CLK_MHZ = 800
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pll_lock,
  input wire logic write_active,
  input wire logic [BYTE_GROUPS-1:0] dqs_in,
  input wire logic fabric_rst,
  input wire logic fabric_clk_en,
  input wire logic mem_clk,
  input wire logic sync_pulse,
  input wire logic [2:0] ref2_mult,
  input wire logic ref_ok,
  input wire logic vco_ok,
  input wire logic cal_rst,
  input wire mpc_pkg::mpc_wr_grp_t [BYTE_GROUPS-1:0] wr_grp,
  input wire mpc_pkg::mpc_rd_grp_t [BYTE_GROUPS-1:0] rd_grp
);
  // second reference multiple that keeps it inside the band
  localparam logic [2:0] REF2 = MEM_CLK_MHZ >= 400 ? 3'h1 :
    (MEM_CLK_MHZ >= 200 ? 3'h2 : 3'h4);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sync_gap_a: assert property (disable iff (rst || fabric_rst)
    sync_pulse |=> !sync_pulse[*8] ##1 !sync_pulse[*7] ##1 sync_pulse)
    else $error("sync pulse spacing wrong");
  fab_rate_a: assert property (disable iff (rst || fabric_rst)
    fabric_clk_en |=> !fabric_clk_en[*3] ##1 fabric_clk_en)
    else $error("fabric enable not every fourth cycle");
  mem_toggle_a: assert property (!fabric_rst ##1 !fabric_rst
    |-> mem_clk != $past(mem_clk)) else $error("memory clock stuck");
  ref_mult_a: assert property (ref2_mult == REF2)
    else $error("second reference multiple wrong");
  byte_shape_a: assert property (disable iff (rst || fabric_rst)
    $rose(wr_grp[0].byte_clk) |-> wr_grp[0].byte_clk ##1
    wr_grp[0].byte_clk ##1 !wr_grp[0].byte_clk ##1 !wr_grp[0].byte_clk
    ##1 wr_grp[0].byte_clk) else $error("byte clock shape wrong");
  shift_lag_a: assert property (!fabric_rst[*3] |->
    wr_grp[0].byte_clk_shifted == $past(wr_grp[0].byte_clk))
    else $error("shifted clock not one cycle late");
  div_period_a: assert property (disable iff (rst || fabric_rst)
    $rose(wr_grp[0].byte_clk_div) |-> ##16 $rose(wr_grp[0].byte_clk_div))
    else $error("divided clock period wrong");
  lock_hold_a: assert property (!pll_lock[*6] |-> fabric_rst)
    else $error("fabric left reset without lock");
  rst_hold_a: assert property ($fell(rst) |-> fabric_rst && cal_rst)
    else $error("resets not held after reset");
  cal_len_a: assert property ($fell(rst) |->
    cal_rst[*8] ##1 cal_rst[*7]) else $error("calibration reset too short");
  wen_quiet_a: assert property (!dqs_in[0][*8] |->
    !rd_grp[0].input_queue_write_enable)
    else $error("input queue write without strobe");
endmodule : mpc_clock_gen_properties
bind mpc_clock_gen mpc_clock_gen_properties #(.BYTE_GROUPS(BYTE_GROUPS),
  .MEM_CLK_MHZ(MEM_CLK_MHZ)) u_props (.clk, .rst, .pll_lock, .write_active,
  .dqs_in, .fabric_rst, .fabric_clk_en, .mem_clk, .sync_pulse, .ref2_mult,
  .ref_ok, .vco_ok, .cal_rst, .wr_grp, .rd_grp);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the memory phy clock block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int BG = 2;
  logic clk = 1'b0; // 250 MHz
  logic rst = 1'b1;
  logic pll_lock = 1'b0;
  logic write_active = 1'b0;
  logic burst = 1'b0; // starts one read burst in the model
  logic [3:0] half = 4'h2;
  logic [BG-1:0] dqs;
  logic fabric_rst, fabric_clk_en, mem_clk, sync_pulse, ref_ok, vco_ok;
  logic cal_rst, prev_mem;
  mpc_pkg::mpc_ref_mult_t ref2_mult;
  mpc_pkg::mpc_wr_grp_t [BG-1:0] wr_grp;
  mpc_pkg::mpc_rd_grp_t [BG-1:0] rd_grp;
  int mismatches = 0;
  int check_count = 0;
  int n_sync, n_en, n_tog, n_byte, n_wen;
  int n_wdiv, n_shift, n_rclk, n_rdiv; // further clock edge counts
  logic prev_byte, prev_wa, prev_fab, prev_wdiv, prev_shift;
  logic prev_rclk, prev_rdiv; // read clocks before the edge
  logic cal_rst_low, ref_ok_low, vco_ok_low; // low rate plan outputs
  mpc_pkg::mpc_ref_mult_t ref2_mult_low;
  logic [31:0] rng = 32'h0001086D; // seed 67693
  always #2 clk = ~clk;
  mpc_clock_gen uut (.clk(clk), .rst(rst), .pll_lock(pll_lock),
    .write_active(write_active), .dqs_in(dqs), .fabric_rst(fabric_rst),
    .fabric_clk_en(fabric_clk_en), .mem_clk(mem_clk),
    .sync_pulse(sync_pulse), .ref2_mult(ref2_mult), .ref_ok(ref_ok),
    .vco_ok(vco_ok), .cal_rst(cal_rst), .wr_grp(wr_grp), .rd_grp(rd_grp));
  mpc_mem_model #(.BG(BG)) mem (.clk(clk), .burst(burst), .half(half),
    .dqs(dqs));
  // low memory clock plan, calibration reference taken from the pll
  mpc_clock_gen #(.MEM_CLK_MHZ(300), .IN_CLK_MHZ(300), .PLL_MULT(4),
    .PLL_DIV(4), .CAL_REF_FROM_PLL(1'b1)) uut_low (.clk(clk), .rst(rst),
    .pll_lock(pll_lock), .write_active(write_active), .dqs_in(dqs),
    .fabric_rst(), .fabric_clk_en(), .mem_clk(), .sync_pulse(),
    .ref2_mult(ref2_mult_low), .ref_ok(ref_ok_low), .vco_ok(vco_ok_low),
    .cal_rst(cal_rst_low), .wr_grp(), .rd_grp());
  // xorshift step, repeatable random stimulus
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift
  // expected multiple of the second phase reference
  function automatic logic [2:0] exp_mult(input int mhz);
    return mhz >= 400 ? 3'h1 : (mhz >= 200 ? 3'h2 : 3'h4);
  endfunction : exp_mult
  // compare one seen value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // step n cycles, random write activity, count output events
  task automatic run(input int n);
    for (int i = 0; i < n; i++)
    begin
      prev_mem = mem_clk;
      prev_byte = wr_grp[0].byte_clk;
      prev_wdiv = wr_grp[0].byte_clk_div;
      prev_shift = wr_grp[0].byte_clk_shifted;
      prev_rclk = rd_grp[0].byte_clk;
      prev_rdiv = rd_grp[0].byte_clk_div;
      prev_wa = write_active;
      prev_fab = fabric_rst;
      @(posedge clk);
      #1;
      rng = xorshift(rng);
      write_active = rng[0];
      if (wr_grp[0].byte_clk_div === 1'b1 && prev_wdiv === 1'b0) n_wdiv++;
      if (wr_grp[0].byte_clk_shifted === 1'b1 && prev_shift === 1'b0)
        n_shift++;
      if (rd_grp[0].byte_clk === 1'b1 && prev_rclk === 1'b0) n_rclk++;
      if (rd_grp[0].byte_clk_div === 1'b1 && prev_rdiv === 1'b0) n_rdiv++;
      // write side outputs follow the activity level of the last cycle; the shifted clock follows the last byte clock
      if (prev_fab === 1'b0)
      begin
        check(wr_grp[0].data_oe_n, !prev_wa);
        check(wr_grp[0].strobe_oe_n, !prev_wa);
        check(wr_grp[0].strobe_gen, prev_wa & wr_grp[0].byte_clk);
        check(wr_grp[0].out_queue_read_enable,
          prev_wa & wr_grp[0].byte_clk & !prev_byte);
        check(wr_grp[0].byte_clk_shifted, prev_byte);
      end
      if (sync_pulse === 1'b1) n_sync++;
      if (fabric_clk_en === 1'b1) n_en++;
      if (mem_clk !== prev_mem) n_tog++;
      if (wr_grp[0].byte_clk === 1'b1 && prev_byte === 1'b0) n_byte++;
      if (rd_grp[0].input_queue_write_enable === 1'b1) n_wen++;
    end
  endtask : run
  // relock and wait a bounded time for the fabric reset to drop
  task automatic relock();
    int k;
    pll_lock = 1'b1;
    for (k = 0; k < 12 && fabric_rst !== 1'b0; k++) run(1);
    if (k == 12)
    begin
      check(fabric_rst, 32'h0);
      end_of_test();
    end
  endtask : relock
  // one read burst at the given strobe half period
  task automatic read_burst(input logic [3:0] h);
    half = h;
    n_wen = 0;
    n_rclk = 0;
    n_rdiv = 0;
    burst = 1'b1;
    run(1);
    burst = 1'b0;
    run(16 * h + 24);
    check(n_wen, 32'h2);
    check(n_rclk, 32'h8);
    check(n_rdiv, 32'h2);
  endtask : read_burst
  initial
  begin
    run(16);
    rst = 1'b0;
    run(3);
    check(cal_rst, 32'h1);
    run(20);
    check(fabric_rst, 32'h1);
    check(cal_rst, 32'h0);
    check(cal_rst_low, 32'h1);
    relock();
    run(8);
    {n_sync, n_en, n_tog, n_byte, n_wdiv, n_shift} = '0;
    run(64);
    check(n_wdiv, 32'h4);
    check(n_shift, 32'h10);
    check(cal_rst_low, 32'h0);
    check(ref2_mult_low, exp_mult(300));
    check(ref_ok, 32'h1);
    check(vco_ok, 32'h1);
    check(ref_ok_low, 32'h1);
    check(vco_ok_low, 32'h1);
    check(n_sync, 32'h4);
    check(n_en, 32'h10);
    check(n_tog, 32'h40);
    check(n_byte, 32'h10);
    check(ref2_mult, exp_mult(800));
    read_burst(4'h2);
    read_burst(4'h4);
    pll_lock = 1'b0;
    run(8);
    check(fabric_rst, 32'h1);
    check(cal_rst_low, 32'h1);
    relock();
    rst = 1'b1;
    run(2);
    rst = 1'b0;
    run(1);
    check(fabric_rst, 32'h1);
    check(cal_rst, 32'h1);
    run(30);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
